// ===== pkg/dim_pkg.sv
package dim_pkg;

	// ------------------------------------------------------------
	// Clocking and time conversion
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CK_HALF       = 1;
	localparam int TCK_NS        = CLK_PERIOD_NS * 2 * CK_HALF;

	// Converts a least time in ns into whole memory clock periods, never below one.
	function automatic int ns_to_tck(input int ns);
		int n;
		n = (ns + TCK_NS - 1) / TCK_NS;
		return (n < 1) ? 1 : n;
	endfunction

	// Returns the larger of two figures.
	function automatic int max2(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	// ------------------------------------------------------------
	// Timing figures, given in ns or us or in memory clock periods
	// ------------------------------------------------------------
	localparam int T_RST_PWR_US        = 200;
	localparam int T_RST_PWR_TCK       = ns_to_tck(T_RST_PWR_US * 1000);
	localparam int T_RST_STBL_NS       = 100;
	localparam int T_CKE_PRE_NS        = 10;
	localparam int T_RST_STBL_TCK      = max2(ns_to_tck(T_RST_STBL_NS), ns_to_tck(T_CKE_PRE_NS));
	localparam int T_CKE_WAIT_US       = 500;
	localparam int T_CKE_WAIT_TCK      = ns_to_tck(T_CKE_WAIT_US * 1000);
	localparam int T_CK_STABLE_NS      = 10;
	localparam int T_CK_STABLE_MIN_TCK = 5;
	localparam int T_CK_STABLE_TCK     = max2(ns_to_tck(T_CK_STABLE_NS), T_CK_STABLE_MIN_TCK);
	localparam int TXS_NS              = 180;
	localparam int TXPR_MIN_TCK        = 5;
	localparam int TXPR_TCK            = max2(ns_to_tck(TXS_NS), TXPR_MIN_TCK);
	localparam int TMRD_TCK            = 4;
	localparam int TMOD_NS             = 15;
	localparam int TMOD_MIN_TCK        = 12;
	localparam int TMOD_TCK            = max2(ns_to_tck(TMOD_NS), TMOD_MIN_TCK);
	localparam int TDLLK_TCK           = 512;
	localparam int TZQINIT_TCK         = 512;
	localparam int TZQ_WAIT_TCK        = max2(TDLLK_TCK, TZQINIT_TCK);
	localparam int CNT_W               = 16;

	// ------------------------------------------------------------
	// Command codes {cs_n, ras_n, cas_n, we_n} and mode register selects
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_NOP  = 4'h7;
	localparam logic [3:0] CMD_MRS  = 4'h0;
	localparam logic [3:0] CMD_ZQCL = 4'h6;
	localparam logic [1:0] MR0_SEL  = 2'h0;
	localparam logic [1:0] MR1_SEL  = 2'h1;
	localparam logic [1:0] MR2_SEL  = 2'h2;
	localparam logic [1:0] MR3_SEL  = 2'h3;

	// ------------------------------------------------------------
	// Address field positions and values after reset
	// ------------------------------------------------------------
	localparam int         DLL_DIS_BIT  = 0;
	localparam int         DLL_RST_BIT  = 8;
	localparam int         ZQ_LONG_BIT  = 10;
	localparam int         WR_LSB       = 9;
	localparam int         WR_MSB       = 11;
	localparam int         RSVD_LSB     = 13;
	localparam logic [2:0] WR_CODE_MIN  = 3'h1;
	localparam logic [15:0] ADDR_RESET  = 16'h0000;
	localparam logic [2:0]  BA_RESET    = 3'h0;

	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_RST_HOLD = 9'h002,
		ST_CKE_WAIT = 9'h004,
		ST_XPR_WAIT = 9'h008,
		ST_MRS_GAP  = 9'h010,
		ST_ZQ_WAIT  = 9'h020,
		ST_READY    = 9'h040,
		ST_USR_PRE  = 9'h080,
		ST_USR_MOD  = 9'h100
	} dim_state_t;

	// Mode register written at a given step of the start-up sequence.
	function automatic logic [1:0] init_sel(input logic [1:0] seq);
		case (seq)
			2'h0: return MR2_SEL;
			2'h1: return MR3_SEL;
			2'h2: return MR1_SEL;
			default: return MR0_SEL;
		endcase
	endfunction

	// Builds {bank, address} for a mode register write from a full register image.
	function automatic logic [18:0] mrs_word(input logic [1:0] sel, input logic [15:0] val, input logic init);
		logic [15:0] a;
		a = val;
		a[15:RSVD_LSB] = 3'h0;
		if (sel == MR1_SEL && init) begin
			a[DLL_DIS_BIT] = 1'b0;
		end
		if (sel == MR0_SEL) begin
			if (init) begin
				a[DLL_RST_BIT] = 1'b1;
			end
			if (a[WR_MSB:WR_LSB] < WR_CODE_MIN) begin
				a[WR_MSB:WR_LSB] = WR_CODE_MIN;
			end
		end
		return {1'b0, sel, a};
	endfunction

endpackage

// ===== hdl/dim_ck_div.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Memory clock divider
// ------------------------------------------------------------
module dim_ck_div #(
	parameter int HALF = 1
) (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	output logic      ck_o,
	output logic      ck_n_o,
	output logic      slot_o
);
	import dim_pkg::*;

	localparam int CW = $clog2(HALF) + 1;
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);

	logic [CW-1:0] phase_reg;
	logic          ck_reg;

	// Counts core cycles in each half period and toggles the memory clock.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= '0;
			ck_reg    <= 1'b0;
		end else if (phase_reg == LAST) begin
			phase_reg <= '0;
			ck_reg    <= ~ck_reg;
		end else begin
			phase_reg <= phase_reg + CW'(1);
		end
	end

	// Slot marks the last core cycle of the high phase; pins change at its end.
	assign slot_o = ck_reg && (phase_reg == LAST);
	assign ck_o   = ck_reg;
	assign ck_n_o = ~ck_reg;

endmodule

// ===== hdl/dim_init_ctrl.sv
`timescale 1ns/1ps

// Contract
// R1 - Hold CKE low 500 us after reset release.
// R2 - Clock stable 10 ns/5 tck before CKE.
// R3 - NOP registered before CKE goes high.
// R4 - Keep CKE high until start-up ends.
// R5 - Memory keeps termination off until CKE high.
// R6 - ODT static, low when nominal termination used.
// R7 - Wait tXPR after CKE before first MRS.
// R8 - Load MR2, MR3, MR1, then MR0.
// R9 - MR1 enables DLL, MR0 requests DLL reset.
// R10 - Issue ZQCL, wait tDLLK and tZQinit.
// R11 - Only NOP between start-up MRS and ZQCL.
// R12 - Warm reset: 100 ns low, CKE low early.
// R13 - Write every mode register before operation.
// R14 - Every MRS drives all address fields.
// R15 - Mode writes leave array contents intact.
// R16 - Space consecutive MRS by tMRD.
// R17 - Wait tMOD before any non-MRS command.
// R18 - Reprogram only while memory is idle.
// R19 - ODT low around MRS when termination enabled.
// R20 - MR0 write drives command and banks low.
// R21 - BA2 and A13-A15 zero during MRS.
// R22 - Write-recovery field at least tWR/tCK.

module dim_init_ctrl #(
	parameter int RST_PWR_TCK  = dim_pkg::T_RST_PWR_TCK,
	parameter int CKE_WAIT_TCK = dim_pkg::max2(dim_pkg::T_CKE_WAIT_TCK, dim_pkg::T_CK_STABLE_TCK)
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic        cold_i,
	input  wire logic [15:0] mr0_i,
	input  wire logic [15:0] mr1_i,
	input  wire logic [15:0] mr2_i,
	input  wire logic [15:0] mr3_i,
	input  wire logic        rtt_nom_en_i,
	input  wire logic        odt_req_i,
	input  wire logic        mrs_req_i,
	input  wire logic [1:0]  mrs_sel_i,
	input  wire logic [15:0] mrs_val_i,
	input  wire logic        dev_idle_i,
	output logic             ddr_reset_n_o,
	output logic             ddr_ck_o,
	output logic             ddr_ck_n_o,
	output logic             ddr_cke_o,
	output logic             ddr_cs_n_o,
	output logic             ddr_ras_n_o,
	output logic             ddr_cas_n_o,
	output logic             ddr_we_n_o,
	output logic [2:0]       ddr_ba_o,
	output logic [15:0]      ddr_addr_o,
	output logic             ddr_odt_o,
	output logic             init_done_o,
	output logic             busy_o,
	output logic             mrs_done_o
);
	import dim_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	dim_state_t       state_reg;
	dim_state_t       state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [1:0]       seq_reg;
	logic [1:0]       seq_next;
	logic [3:0]       cmd_reg;
	logic [3:0]       cmd_next;
	logic [18:0]      word_reg;
	logic [18:0]      word_next;
	logic             rstn_reg;
	logic             rstn_next;
	logic             cke_reg;
	logic             cke_next;
	logic             odt_reg;
	logic             odt_next;
	logic             start_pend_reg;
	logic             mrs_done_reg;
	logic             slot;
	logic             cnt_zero;

	// Returns the start-up image of one mode register.
	function automatic logic [15:0] mr_image(input logic [1:0] sel);
		case (sel)
			MR0_SEL: return mr0_i;
			MR1_SEL: return mr1_i;
			MR2_SEL: return mr2_i;
			default: return mr3_i;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Memory clock
	// ------------------------------------------------------------
	dim_ck_div #(
		.HALF(CK_HALF)
	) u_ck_div (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.ck_o      (ddr_ck_o),
		.ck_n_o    (ddr_ck_n_o),
		.slot_o    (slot)
	);

	// Remembers a start request until the sequencer takes it; a new request wins over the clear.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_pend_reg <= 1'b0;
		end else if (start_i) begin
			start_pend_reg <= 1'b1;
		end else if (slot && state_next == ST_RST_HOLD) begin
			start_pend_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	assign cnt_zero = (cnt_reg == '0);

	// Chooses the next state, the next pin values and the next wait.
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_zero ? cnt_reg : cnt_reg - CNT_W'(1);
		seq_next   = seq_reg;
		// R11 only NOP otherwise
		cmd_next   = CMD_NOP;
		word_next  = {BA_RESET, ADDR_RESET};
		rstn_next  = rstn_reg;
		// R4 CKE kept high
		cke_next   = cke_reg;
		// R6 ODT static low
		odt_next   = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (start_pend_reg) begin
					state_next = ST_RST_HOLD;
					// R12 reset hold length
					cnt_next   = cold_i ? CNT_W'(RST_PWR_TCK) : CNT_W'(T_RST_STBL_TCK);
					rstn_next  = 1'b0;
					cke_next   = 1'b0;
				end
			end
			ST_RST_HOLD: begin
				if (cnt_zero) begin
					state_next = ST_CKE_WAIT;
					// R1 R2 CKE low wait
					cnt_next   = CNT_W'(CKE_WAIT_TCK);
					rstn_next  = 1'b1;
				end
			end
			ST_CKE_WAIT: begin
				// R3 NOP before CKE
				cmd_next = CMD_NOP;
				if (cnt_zero) begin
					state_next = ST_XPR_WAIT;
					cke_next   = 1'b1;
					// R7 tXPR wait
					cnt_next   = CNT_W'(TXPR_TCK);
					seq_next   = 2'h0;
				end
			end
			ST_XPR_WAIT, ST_MRS_GAP: begin
				if (cnt_zero) begin
					if (state_reg == ST_MRS_GAP && seq_reg == 2'h3) begin
						// R10 R17 ZQCL after tMOD
						state_next             = ST_ZQ_WAIT;
						cmd_next               = CMD_ZQCL;
						word_next[ZQ_LONG_BIT] = 1'b1;
						cnt_next               = CNT_W'(TZQ_WAIT_TCK);
					end else begin
						if (state_reg == ST_MRS_GAP) begin
							seq_next = seq_reg + 2'h1;
						end
						state_next = ST_MRS_GAP;
						cmd_next   = CMD_MRS;
						// R8 R9 R13 R14 R20 R21 R22 full image
						word_next  = mrs_word(init_sel(seq_next), mr_image(init_sel(seq_next)), 1'b1);
						// R16 R17 spacing
						cnt_next   = (seq_next == 2'h3) ? CNT_W'(TMOD_TCK) : CNT_W'(TMRD_TCK);
					end
				end
			end
			ST_ZQ_WAIT: begin
				if (cnt_zero) begin
					state_next = ST_READY;
				end
			end
			ST_READY: begin
				odt_next = odt_req_i;
				if (start_pend_reg) begin
					state_next = ST_RST_HOLD;
					cnt_next   = cold_i ? CNT_W'(RST_PWR_TCK) : CNT_W'(T_RST_STBL_TCK);
					rstn_next  = 1'b0;
					cke_next   = 1'b0;
					odt_next   = 1'b0;
				// R18 idle gate
				end else if (mrs_req_i && dev_idle_i) begin
					state_next = ST_USR_PRE;
					// R19 ODT low first
					odt_next   = rtt_nom_en_i ? 1'b0 : odt_req_i;
				end
			end
			ST_USR_PRE: begin
				odt_next   = rtt_nom_en_i ? 1'b0 : odt_req_i;
				state_next = ST_USR_MOD;
				cmd_next   = CMD_MRS;
				// R14 R21 R22 full image
				word_next  = mrs_word(mrs_sel_i, mrs_val_i, 1'b0);
				// R17 tMOD after MRS
				cnt_next   = CNT_W'(TMOD_TCK);
			end
			ST_USR_MOD: begin
				// R19 ODT low until tMOD
				odt_next = rtt_nom_en_i ? 1'b0 : odt_req_i;
				if (cnt_zero) begin
					state_next = ST_READY;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Advances the sequencer once per memory clock period.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
			seq_reg   <= 2'h0;
		end else if (slot) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			seq_reg   <= seq_next;
		end
	end

	// Registers the pins so they change half a period before the memory samples them.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_reg  <= CMD_NOP;
			word_reg <= {BA_RESET, ADDR_RESET};
			rstn_reg <= 1'b0;
			cke_reg  <= 1'b0;
			odt_reg  <= 1'b0;
		end else if (slot) begin
			cmd_reg  <= cmd_next;
			word_reg <= word_next;
			rstn_reg <= rstn_next;
			cke_reg  <= cke_next;
			odt_reg  <= odt_next;
		end
	end

	// Pulses once when a user mode register write has served its tMOD.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mrs_done_reg <= 1'b0;
		end else begin
			mrs_done_reg <= slot && (state_reg == ST_USR_MOD) && cnt_zero;
		end
	end

	// Pin and status outputs.
	assign {ddr_cs_n_o, ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o} = cmd_reg;
	assign ddr_ba_o      = word_reg[18:16];
	assign ddr_addr_o    = word_reg[15:0];
	assign ddr_reset_n_o = rstn_reg;
	assign ddr_cke_o     = cke_reg;
	assign ddr_odt_o     = odt_reg;
	assign init_done_o   = (state_reg == ST_READY);
	assign busy_o        = (state_reg != ST_READY) && (state_reg != ST_IDLE);
	assign mrs_done_o    = mrs_done_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [CNT_W-1:0] rst_low_cnt;
	logic [CNT_W-1:0] cke_low_cnt;
	logic [CNT_W-1:0] since_cke;
	logic [CNT_W-1:0] since_mrs;
	logic [1:0]       last_ba;
	logic             prev_cke;
	logic             init_phase;
	logic             mrs_on;

	// Increments a count without wrapping.
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		return (&v) ? v : v + CNT_W'(1);
	endfunction

	assign init_phase = (state_reg == ST_XPR_WAIT) || (state_reg == ST_MRS_GAP) || (state_reg == ST_ZQ_WAIT);
	assign mrs_on     = (cmd_reg == CMD_MRS);

	// Counts memory clock periods seen on the pins.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_low_cnt <= '0;
			cke_low_cnt <= '0;
			since_cke   <= '0;
			since_mrs   <= '1;
			last_ba     <= 2'h0;
			prev_cke    <= 1'b0;
		end else if (slot) begin
			rst_low_cnt <= ddr_reset_n_o ? '0 : sat_inc(rst_low_cnt);
			cke_low_cnt <= (ddr_reset_n_o && !ddr_cke_o) ? sat_inc(cke_low_cnt) : '0;
			since_cke   <= ddr_cke_o ? sat_inc(since_cke) : '0;
			since_mrs   <= mrs_on ? '0 : sat_inc(since_mrs);
			last_ba     <= mrs_on ? ddr_ba_o[1:0] : last_ba;
			prev_cke    <= ddr_cke_o;
		end
	end

	property p_rst_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(ddr_reset_n_o) |-> (rst_low_cnt >= CNT_W'(T_RST_STBL_TCK)) && !ddr_cke_o;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset released too early"); // R12

	property p_cke_wait;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && ddr_cke_o && !prev_cke) |-> cke_low_cnt >= CNT_W'(CKE_WAIT_TCK);
	endproperty
	a_cke_wait: assert property (p_cke_wait) else $error("CKE raised before the wait ended"); // R1

	property p_nop_before_cke;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(ddr_cke_o) |-> $past(cmd_reg, 2) == CMD_NOP;
	endproperty
	a_nop_before_cke: assert property (p_nop_before_cke) else $error("no NOP before CKE high"); // R3

	property p_cke_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(init_phase && ddr_cke_o) |=> ddr_cke_o;
	endproperty
	a_cke_hold: assert property (p_cke_hold) else $error("CKE dropped during start-up"); // R4

	property p_odt_init;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		init_phase |-> !ddr_odt_o ##1 !ddr_odt_o;
	endproperty
	a_odt_init: assert property (p_odt_init) else $error("ODT moved during start-up"); // R6

	property p_first_mrs;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && mrs_on && init_phase && ddr_ba_o[1:0] == MR2_SEL) |-> since_cke >= CNT_W'(TXPR_TCK);
	endproperty
	a_first_mrs: assert property (p_first_mrs) else $error("first MRS before tXPR"); // R7

	property p_mrs_order;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && mrs_on && init_phase && ddr_ba_o[1:0] != MR2_SEL) |->
			ddr_ba_o[1:0] == ((last_ba == MR2_SEL) ? MR3_SEL : (last_ba == MR3_SEL) ? MR1_SEL : MR0_SEL);
	endproperty
	a_mrs_order: assert property (p_mrs_order) else $error("mode registers out of order"); // R8

	property p_dll_bits;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && mrs_on && init_phase) |->
			(ddr_ba_o[1:0] != MR1_SEL || !ddr_addr_o[DLL_DIS_BIT]) && (ddr_ba_o[1:0] != MR0_SEL || ddr_addr_o[DLL_RST_BIT]);
	endproperty
	a_dll_bits: assert property (p_dll_bits) else $error("DLL enable or reset bit wrong"); // R9

	property p_tmrd;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && mrs_on) |-> since_mrs >= CNT_W'(TMRD_TCK - 1);
	endproperty
	a_tmrd: assert property (p_tmrd) else $error("MRS spacing below tMRD"); // R16

	property p_tmod;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && cmd_reg == CMD_ZQCL) |-> since_mrs >= CNT_W'(TMOD_TCK - 1);
	endproperty
	a_tmod: assert property (p_tmod) else $error("command within tMOD of MRS"); // R17

	property p_rsvd_zero;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && mrs_on) |-> !ddr_ba_o[2] && ddr_addr_o[15:RSVD_LSB] == 3'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved MRS bits not zero"); // R21

	property p_odt_mrs;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(slot && mrs_on && !init_phase && rtt_nom_en_i) |-> !ddr_odt_o && !$past(ddr_odt_o, 1);
	endproperty
	a_odt_mrs: assert property (p_odt_mrs) else $error("ODT high around MRS"); // R19

endmodule

// ===== testbench/dim_dev_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Memory device model, pins sampled on each rising memory clock
// ------------------------------------------------------------
module dim_dev_model (
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ck_i,
	input  wire logic        cke_i,
	input  wire logic        cs_n_i,
	input  wire logic        ras_n_i,
	input  wire logic        cas_n_i,
	input  wire logic        we_n_i,
	input  wire logic [2:0]  ba_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        odt_i,
	output logic             rtt_on_o
);
	import dim_pkg::*;

	logic [15:0] mr [4];
	logic [7:0]  cells [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
	int          ev_code [$];
	int          ev_tck [$];
	logic [15:0] ev_addr [$];
	logic [2:0]  ev_ba [$];
	int          tck = 0;
	int          rel_tck = 0;
	int          cke_tck = 0;
	int          rst_len = 0;
	int          cke_wait = 0;
	int          cke_drop = 0;
	int          bad_cmd = 0;
	logic        ck_q = 1'b0;
	logic        rst_q = 1'b1;
	logic        cke_seen = 1'b0;
	logic        cke_at_rel = 1'b1;
	logic        nop_seen = 1'b0;
	logic        nop_before_cke = 1'b0;
	logic        zq_seen = 1'b0;
	logic [3:0]  cmd;

	// Command code of the pins, chip select first.
	assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};

	assign rtt_on_o = reset_n_i & cke_seen & odt_i;

	// Registers the pins at each memory clock rise and logs every MRS and ZQCL once CKE has gone high.
	always @(posedge core_clk_i) begin
		if (ck_i === 1'b1 && ck_q === 1'b0) begin
			tck = tck + 1;
			if (reset_n_i !== 1'b1) begin
				for (int i = 0; i < 4; i++) begin
					mr[i] = 'x;
				end
				rst_len = rst_q ? 1 : rst_len + 1;
				cke_seen = 1'b0;
				zq_seen = 1'b0;
			end else begin
				if (!rst_q) begin
					rel_tck = tck;
					cke_at_rel = cke_i;
				end
				if (cke_i === 1'b1 && !cke_seen) begin
					cke_seen = 1'b1;
					cke_tck = tck;
					cke_wait = tck - rel_tck;
					nop_before_cke = nop_seen;
				end else if (cke_i !== 1'b1 && cke_seen && !zq_seen) begin
					cke_drop = cke_drop + 1;
				end
				nop_seen = (cmd === CMD_NOP);
				if (cke_seen && cmd === CMD_MRS) begin
					mr[ba_i[1:0]] = addr_i;
					ev_code.push_back(int'(ba_i[1:0]));
				end else if (cke_seen && cmd === CMD_ZQCL) begin
					zq_seen = 1'b1;
					ev_code.push_back(4);
				end else if (cke_seen && cmd !== CMD_NOP) begin
					bad_cmd = bad_cmd + 1;
				end
				if (cke_seen && (cmd === CMD_MRS || cmd === CMD_ZQCL)) begin
					ev_tck.push_back(tck);
					ev_addr.push_back(addr_i);
					ev_ba.push_back(ba_i);
				end
			end
			rst_q = reset_n_i;
		end
		ck_q = ck_i;
	end
endmodule

// ===== testbench/tb_dim_init_ctrl.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Bench for the start-up and mode write controller
// ------------------------------------------------------------
module tb_dim_init_ctrl;
	import dim_pkg::*;

	localparam int PWR_TB   = 10;
	localparam int CKE_TB   = 8;
	localparam int WATCH_NS = 10000 * CLK_PERIOD_NS;

	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        start_i = 1'b0;
	logic        cold_i = 1'b1;
	logic        rtt_nom_en_i = 1'b0;
	logic        odt_req_i = 1'b0;
	logic        mrs_req_i = 1'b0;
	logic        dev_idle_i = 1'b0;
	logic [1:0]  mrs_sel_i = 2'h0;
	logic [15:0] mrs_val_i = 16'h0000;
	logic        ddr_reset_n_o, ddr_ck_o, ddr_ck_n_o, ddr_cke_o, ddr_cs_n_o, ddr_ras_n_o;
	logic        ddr_cas_n_o, ddr_we_n_o, ddr_odt_o, init_done_o, busy_o, mrs_done_o, rtt_on;
	logic [2:0]  ddr_ba_o;
	logic [15:0] ddr_addr_o;
	int          num_errors = 0;
	int          total_checks = 0;
	int          odt_bad = 0;
	logic        init_op = 1'b0;
	int          seq [5] = '{2, 3, 1, 0, 4};
	logic [15:0] exp_mr [4] = '{16'h0324, 16'h0046, 16'h0018, 16'h0004};
	logic [15:0] usr_val [4] = '{16'hE000, 16'h2001, 16'h4510, 16'h8004};
	logic [15:0] usr_exp [4] = '{16'h0200, 16'h0001, 16'h0510, 16'h0004};

	dim_init_ctrl #(.RST_PWR_TCK(PWR_TB), .CKE_WAIT_TCK(CKE_TB)) dim_init_ctrl_i (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .cold_i(cold_i),
		.mr0_i(16'hE024), .mr1_i(16'hA047), .mr2_i(16'h2018), .mr3_i(16'h4004),
		.rtt_nom_en_i(rtt_nom_en_i), .odt_req_i(odt_req_i), .mrs_req_i(mrs_req_i),
		.mrs_sel_i(mrs_sel_i), .mrs_val_i(mrs_val_i), .dev_idle_i(dev_idle_i),
		.ddr_reset_n_o(ddr_reset_n_o), .ddr_ck_o(ddr_ck_o), .ddr_ck_n_o(ddr_ck_n_o), .ddr_cke_o(ddr_cke_o),
		.ddr_cs_n_o(ddr_cs_n_o), .ddr_ras_n_o(ddr_ras_n_o), .ddr_cas_n_o(ddr_cas_n_o), .ddr_we_n_o(ddr_we_n_o),
		.ddr_ba_o(ddr_ba_o), .ddr_addr_o(ddr_addr_o), .ddr_odt_o(ddr_odt_o), .init_done_o(init_done_o),
		.busy_o(busy_o), .mrs_done_o(mrs_done_o));

	dim_dev_model dim_dev_model_i (
		.core_clk_i(core_clk_i), .reset_n_i(ddr_reset_n_o), .ck_i(ddr_ck_o), .cke_i(ddr_cke_o),
		.cs_n_i(ddr_cs_n_o), .ras_n_i(ddr_ras_n_o), .cas_n_i(ddr_cas_n_o), .we_n_i(ddr_we_n_o),
		.ba_i(ddr_ba_o), .addr_i(ddr_addr_o), .odt_i(ddr_odt_o), .rtt_on_o(rtt_on));

	// Free-running core clock.
	always #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;

	// Counts termination pin activity where it must stay low.
	always @(posedge core_clk_i) begin
		if (init_op && ddr_cke_o === 1'b1 && ddr_odt_o !== 1'b0) begin
			odt_bad++;
		end
		if (busy_o === 1'b1 && !init_op && rtt_nom_en_i && ddr_odt_o !== 1'b0) begin
			odt_bad++;
		end
	end

	// Moves to just after the next rising edge, where inputs change.
	task automatic step;
		@(posedge core_clk_i);
		#1;
	endtask

	// Compares one value and records the outcome.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Runs a full start-up and checks the commands the device registered.
	task automatic run_init(input logic cold, input int hold_min);
		int n;
		int b;
		b = dim_dev_model_i.ev_code.size();
		cold_i = cold;
		start_i = 1'b1;
		step;
		start_i = 1'b0;
		for (n = 0; n < 20 && busy_o !== 1'b1; n++) begin
			step;
		end
		init_op = 1'b1;
		for (n = 0; n < 4000 && init_done_o !== 1'b1; n++) begin
			step;
		end
		init_op = 1'b0;
		check("init done", init_done_o, 1);
		check("reset hold", dim_dev_model_i.rst_len >= hold_min, 1);
		check("cke at release", dim_dev_model_i.cke_at_rel, 0);
		check("cke wait", dim_dev_model_i.cke_wait >= CKE_TB, 1);
		check("clock before cke", dim_dev_model_i.cke_wait >= T_CK_STABLE_MIN_TCK, 1);
		check("nop before cke", dim_dev_model_i.nop_before_cke, 1);
		check("cke drops", dim_dev_model_i.cke_drop, 0);
		check("other commands", dim_dev_model_i.bad_cmd, 0);
		check("init commands", dim_dev_model_i.ev_code.size(), b + 5);
		check("xpr wait", dim_dev_model_i.ev_tck[b] - dim_dev_model_i.cke_tck >= TXPR_TCK, 1);
		for (int i = 0; i < 4; i++) begin
			check("command kind", dim_dev_model_i.ev_code[b + i], seq[i]);
			check("bank bits", dim_dev_model_i.ev_ba[b + i], {1'b0, seq[i][1:0]});
			check("mode image", dim_dev_model_i.ev_addr[b + i], exp_mr[seq[i]]);
			check("command gap", dim_dev_model_i.ev_tck[b + i + 1] - dim_dev_model_i.ev_tck[b + i]
				>= ((i < 3) ? TMRD_TCK : TMOD_TCK), 1);
		end
		check("calibration kind", dim_dev_model_i.ev_code[b + 4], 4);
		check("long calibration", dim_dev_model_i.ev_addr[b + 4][10], 1);
		check("calibration wait", dim_dev_model_i.tck - dim_dev_model_i.ev_tck[b + 4] >= TZQ_WAIT_TCK, 1);
	endtask

	// Requests one mode write, first while the memory is not idle.
	task automatic user_mrs(input logic [1:0] sel, input logic [15:0] val, input logic [15:0] exp, input logic rtt);
		int n;
		int b;
		b = dim_dev_model_i.ev_code.size();
		rtt_nom_en_i = rtt;
		mrs_sel_i = sel;
		mrs_val_i = val;
		mrs_req_i = 1'b1;
		repeat (40) step;
		check("write while active", dim_dev_model_i.ev_code.size(), b);
		dev_idle_i = 1'b1;
		for (n = 0; n < 200 && mrs_done_o !== 1'b1; n++) begin
			step;
		end
		mrs_req_i = 1'b0;
		dev_idle_i = 1'b0;
		check("write done", mrs_done_o, 1);
		check("write count", dim_dev_model_i.ev_code.size(), b + 1);
		check("write target", dim_dev_model_i.ev_code[b], sel);
		check("write image", dim_dev_model_i.mr[sel], exp);
		check("mod wait", dim_dev_model_i.tck - dim_dev_model_i.ev_tck[b] >= TMOD_TCK, 1);
		repeat (4) step;
	endtask

	// Main sequence.
	initial begin
		repeat (3) step;
		check("reset pin", ddr_reset_n_o, 0);
		check("cke in reset", ddr_cke_o, 0);
		check("termination in reset", rtt_on, 0);
		check("clock pair", {ddr_ck_o, ddr_ck_n_o}, 2'h1);
		step;
		rst_n_i = 1'b1;
		step;
		run_init(1'b1, PWR_TB);
		odt_req_i = 1'b1;
		for (int i = 0; i < 4; i++) begin
			user_mrs(i[1:0], usr_val[i], usr_exp[i], i == 0);
		end
		run_init(1'b0, (T_RST_STBL_NS + TCK_NS - 1) / TCK_NS);
		check("odt activity", odt_bad, 0);
		check("array kept", {dim_dev_model_i.cells[0], dim_dev_model_i.cells[3]}, 16'h5AC3);
		close_out;
	end

	// Cuts a hang short.
	initial begin
		#(WATCH_NS);
		num_errors++;
		close_out;
	end
endmodule
